// *** design/ascp_defs.svh ***
// Register map, reset values, field positions and character codes of the command parser.
`ifndef ASCP_DEFS_SVH
`define ASCP_DEFS_SVH
`define ASCP_REG_ADDR 3'h0
`define ASCP_REG_FORMAT 3'h1
`define ASCP_REG_CHEN 3'h2
`define ASCP_REG_PROTO 3'h3
`define ASCP_REG_STATUS 3'h4
`define ASCP_ADDR_RST 8'h01
`define ASCP_FORMAT_RST 8'h00
`define ASCP_CHEN_RST 4'hF
`define ASCP_FMT_CKSUM_BIT 6
`define ASCP_FMT_ENG 2'h0
`define ASCP_FMT_PCT 2'h1
`define ASCP_FMT_HEX 2'h2
`define ASCP_CH_CR 8'h0D
`define ASCP_CH_SPACE 8'h20
`define ASCP_CH_ACK 8'h21
`define ASCP_CH_HASH 8'h23
`define ASCP_CH_DOLLAR 8'h24
`define ASCP_CH_PLUS 8'h2B
`define ASCP_CH_MINUS 8'h2D
`define ASCP_CH_POINT 8'h2E
`define ASCP_CH_ZERO 8'h30
`define ASCP_CH_OFFSET 8'h31
`define ASCP_CH_LAST_CHAN 8'h33
`define ASCP_CH_NINE 8'h39
`define ASCP_CH_DATA 8'h3E
`define ASCP_CH_NAK 8'h3F
`define ASCP_CH_A 8'h41
`define ASCP_CH_F 8'h46
`define ASCP_BUF_DEPTH 8
`define ASCP_BUF_FULL 4'h8
`define ASCP_DEC_WIDTH 3'h7
`define ASCP_HEX_WIDTH 3'h4
`define ASCP_LAST_CHAN 2'h3
`define ASCP_LAST_PLACE 3'h4
`define ASCP_MAG_MAX 20'h1_869F
`endif

// *** design/ascp_pkg.sv ***
// Types shared by the command parser and its decimal converter.
package ascp_pkg;
  typedef enum {S_IDLE, S_COLLECT, S_EVAL, S_HEAD, S_ADDR, S_CONV, S_FIELD, S_CKSUM, S_CR} ascp_state_t;
  typedef enum {R_ACK, R_NAK, R_DATA} ascp_resp_t;
  typedef logic signed [19:0] ascp_value_t;
endpackage

// *** design/ascp_dec_conv.sv ***
// Signed value to sign flag and five decimal digits by repeated subtraction.
`timescale 1ns/1ps
`default_nettype none
`include "ascp_defs.svh"
module ascp_dec_conv
  import ascp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire ascp_value_t value,
  // Result
  output logic busy,
  output logic neg,
  output logic [19:0] digits
);
  logic [19:0] rem;
  logic [2:0] place;
  logic [3:0] cnt;

  function automatic logic [19:0] place_weight(input logic [2:0] p);
    unique case (p)
      3'h0: place_weight = 20'h0_2710;
      3'h1: place_weight = 20'h0_03E8;
      3'h2: place_weight = 20'h0_0064;
      3'h3: place_weight = 20'h0_000A;
      default: place_weight = 20'h0_0001;
    endcase
  endfunction

  wire [19:0] weight = place_weight(place);
  wire [19:0] mag_raw = value[19] ? 20'(-value) : value;
  // Magnitudes beyond five digits saturate at the largest printable value.
  wire [19:0] mag = (mag_raw > `ASCP_MAG_MAX) ? `ASCP_MAG_MAX : mag_raw;
  wire fits = rem >= weight;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      busy <= 1'b0;
      neg <= 1'b0;
      digits <= 20'h0_0000;
      rem <= 20'h0_0000;
      place <= 3'h0;
      cnt <= 4'h0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      neg <= value[19];
      rem <= mag;
      place <= 3'h0;
      cnt <= 4'h0;
    end
    else if (busy && fits)
    begin
      rem <= rem - weight;
      cnt <= cnt + 4'h1;
    end
    else if (busy)
    begin
      digits <= {digits[15:0], cnt};
      cnt <= 4'h0;
      place <= place + 3'h1;
      busy <= (place != `ASCP_LAST_PLACE);
    end

  conv_ends_a: assert property (@(posedge clk) disable iff (!rst_n) $rose(busy) |-> ##[1:50] !busy)
    else $error("decimal conversion did not finish in time");
  digit_range_a: assert property (@(posedge clk) disable iff (!rst_n) $fell(busy) |-> digits[3:0] <= 4'h9)
    else $error("converted digit is not decimal");
endmodule
`default_nettype wire

// *** design/ascp_parser.sv ***
// Addressed ASCII command parser with read-all-channels and offset/gain calibration.
`timescale 1ns/1ps
`default_nettype none
`include "ascp_defs.svh"
module ascp_parser
  import ascp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Transmitted characters
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Channel samples
  input wire ascp_value_t ch0_value,
  input wire ascp_value_t ch1_value,
  input wire ascp_value_t ch2_value,
  input wire ascp_value_t ch3_value
);
  logic rst_meta;
  logic rst_n;
  logic [7:0] own_addr;
  logic [7:0] fmt_byte;
  logic [3:0] ch_en;
  logic proto_modbus;
  logic [3:0] off_done;
  logic [3:0] gain_done;
  ascp_value_t cal_off [4];
  ascp_value_t cal_gain [4];
  ascp_state_t state;
  ascp_state_t next_state;
  ascp_resp_t resp;
  logic [7:0] lead;
  logic [7:0] rx_buf [`ASCP_BUF_DEPTH];
  logic [3:0] cnt;
  logic ovf;
  logic [7:0] sum;
  logic [7:0] sum_b1;
  logic [7:0] sum_b2;
  logic [7:0] resp_addr;
  logic [7:0] tx_sum;
  logic [2:0] idx;
  logic [1:0] chan;
  logic conv_go;
  logic conv_busy;
  logic conv_neg;
  logic [19:0] conv_digits;
  logic [7:0] tx_char;

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= `ASCP_CH_ZERO && c <= `ASCP_CH_NINE) || (c >= `ASCP_CH_A && c <= `ASCP_CH_F);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c <= `ASCP_CH_NINE) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n <= 4'h9) ? (`ASCP_CH_ZERO | {4'h0, n}) : 8'(`ASCP_CH_A - 8'h0A + {4'h0, n});
  endfunction

  function automatic logic [7:0] dec_char(input logic [2:0] i, input logic n, input logic [19:0] d);
    unique case (i)
      3'h0: dec_char = n ? `ASCP_CH_MINUS : `ASCP_CH_PLUS;
      3'h1: dec_char = `ASCP_CH_ZERO | {4'h0, d[19:16]};
      3'h2: dec_char = `ASCP_CH_ZERO | {4'h0, d[15:12]};
      3'h3: dec_char = `ASCP_CH_POINT;
      3'h4: dec_char = `ASCP_CH_ZERO | {4'h0, d[11:8]};
      3'h5: dec_char = `ASCP_CH_ZERO | {4'h0, d[7:4]};
      default: dec_char = `ASCP_CH_ZERO | {4'h0, d[3:0]};
    endcase
  endfunction

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end

  wire ascp_value_t ch_value [4];
  assign ch_value[0] = ch0_value;
  assign ch_value[1] = ch1_value;
  assign ch_value[2] = ch2_value;
  assign ch_value[3] = ch3_value;

  // Register slave: one wait cycle, then the access completes.
  wire bus_req = avs_read | avs_write;
  wire bus_wr = avs_write & ~avs_waitrequest;
  wire wr_addr = bus_wr & (avs_address == {1'b0, `ASCP_REG_ADDR});
  wire wr_fmt = bus_wr & (avs_address == {1'b0, `ASCP_REG_FORMAT});
  wire wr_chen = bus_wr & (avs_address == {1'b0, `ASCP_REG_CHEN});
  wire wr_proto = bus_wr & (avs_address == {1'b0, `ASCP_REG_PROTO});
  wire wr_status = bus_wr & (avs_address == {1'b0, `ASCP_REG_STATUS});
  wire ascp_value_t cal_sel = avs_address[2] ? cal_gain[avs_address[1:0]] : cal_off[avs_address[1:0]];
  wire [31:0] rd_low =
    (avs_address[2:0] == `ASCP_REG_ADDR) ? {24'h00_0000, own_addr} :
    (avs_address[2:0] == `ASCP_REG_FORMAT) ? {24'h00_0000, fmt_byte} :
    (avs_address[2:0] == `ASCP_REG_CHEN) ? {28'h000_0000, ch_en} :
    (avs_address[2:0] == `ASCP_REG_PROTO) ? {31'h0000_0000, proto_modbus} :
    (avs_address[2:0] == `ASCP_REG_STATUS) ? {23'h00_0000, gain_done, off_done, state != S_IDLE} :
    32'h0000_0000;
  wire [31:0] rd_mux = avs_address[3] ? {{12{cal_sel[19]}}, cal_sel} : rd_low;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      avs_readdata <= (bus_req & avs_waitrequest) ? rd_mux : avs_readdata;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      own_addr <= `ASCP_ADDR_RST;
      fmt_byte <= `ASCP_FORMAT_RST;
      ch_en <= `ASCP_CHEN_RST;
      proto_modbus <= 1'b0;
    end
    else
    begin
      own_addr <= wr_addr ? avs_writedata[7:0] : own_addr;
      fmt_byte <= wr_fmt ? avs_writedata[7:0] : fmt_byte;
      ch_en <= wr_chen ? avs_writedata[3:0] : ch_en;
      proto_modbus <= wr_proto ? avs_writedata[0] : proto_modbus;
    end

  wire ck_en = fmt_byte[`ASCP_FMT_CKSUM_BIT];
  wire is_hexfmt = fmt_byte[1:0] == `ASCP_FMT_HEX;
  wire [2:0] width = is_hexfmt ? `ASCP_HEX_WIDTH : `ASCP_DEC_WIDTH;

  wire rx_take = rx_valid & rx_ready & ~proto_modbus;
  wire rx_cr = rx_data == `ASCP_CH_CR;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      lead <= 8'h00;
      cnt <= 4'h0;
      ovf <= 1'b0;
      sum <= 8'h00;
      sum_b1 <= 8'h00;
      sum_b2 <= 8'h00;
    end
    else if (state == S_IDLE && rx_take && !rx_cr)
    begin
      lead <= rx_data;
      cnt <= 4'h0;
      ovf <= 1'b0;
      sum <= rx_data;
      sum_b1 <= 8'h00;
      sum_b2 <= 8'h00;
    end
    else if (state == S_COLLECT && rx_take && !rx_cr)
    begin
      ovf <= ovf | (cnt == `ASCP_BUF_FULL);
      cnt <= (cnt == `ASCP_BUF_FULL) ? cnt : cnt + 4'h1;
      sum <= sum + rx_data;
      sum_b1 <= sum;
      sum_b2 <= sum_b1;
    end

  always_ff @(posedge clk)
    if (state == S_COLLECT && rx_take && !rx_cr && cnt != `ASCP_BUF_FULL)
      rx_buf[cnt[2:0]] <= rx_data;

  wire [3:0] pay_len = ck_en ? cnt - 4'h2 : cnt;
  wire [7:0] ck_hi = rx_buf[3'(cnt - 4'h2)];
  wire [7:0] ck_lo = rx_buf[3'(cnt - 4'h1)];
  wire ck_ok = ~ck_en | ((cnt >= 4'h2) & is_hex(ck_hi) & is_hex(ck_lo) & ({hex_val(ck_hi), hex_val(ck_lo)} == sum_b2));
  wire addr_ok = (pay_len >= 4'h2) & is_hex(rx_buf[0]) & is_hex(rx_buf[1])
    & ({hex_val(rx_buf[0]), hex_val(rx_buf[1])} == own_addr);
  wire silent = ovf | ~ck_ok | ~addr_ok;
  wire read_all = (lead == `ASCP_CH_HASH) & (pay_len == 4'h2);
  wire cal_cmd = (lead == `ASCP_CH_DOLLAR) & (pay_len == 4'h4) & ~proto_modbus
    & ((rx_buf[2] == `ASCP_CH_ZERO) | (rx_buf[2] == `ASCP_CH_OFFSET))
    & (rx_buf[3] >= `ASCP_CH_ZERO) & (rx_buf[3] <= `ASCP_CH_LAST_CHAN);
  wire is_offset = rx_buf[2] == `ASCP_CH_OFFSET;
  wire [1:0] cal_ch = rx_buf[3][1:0];
  wire ascp_value_t cal_pick = ch_value[cal_ch];
  wire do_cal = (state == S_EVAL) & ~silent & cal_cmd;

  always_ff @(posedge clk)
    if (do_cal && is_offset)
      cal_off[cal_ch] <= cal_pick;
    else if (do_cal)
      cal_gain[cal_ch] <= cal_pick;

  wire [3:0] cal_bit = 4'(1 << cal_ch);
  wire [3:0] off_clr = wr_status ? avs_writedata[4:1] : 4'h0;
  wire [3:0] gain_clr = wr_status ? avs_writedata[8:5] : 4'h0;

  // A capture in the same cycle as a software clear keeps its flag.
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      off_done <= 4'h0;
      gain_done <= 4'h0;
    end
    else
    begin
      off_done <= (off_done & ~off_clr) | ((do_cal & is_offset) ? cal_bit : 4'h0);
      gain_done <= (gain_done & ~gain_clr) | ((do_cal & ~is_offset) ? cal_bit : 4'h0);
    end

  // Response side.
  wire send_state = state inside {S_HEAD, S_ADDR, S_FIELD, S_CKSUM, S_CR};
  wire load = send_state & (~tx_valid | tx_ready);
  wire ascp_value_t cur_val = ch_value[chan];
  wire [15:0] hex_shift = cur_val[15:0] >> {2'(~idx[1:0]), 2'b00};
  wire last_idx = idx == 3'(width - 3'h1);
  ascp_state_t tail_state;
  assign tail_state = ck_en ? S_CKSUM : S_CR;

  wire [7:0] field_char = !ch_en[chan] ? `ASCP_CH_SPACE :
    is_hexfmt ? hex_char(hex_shift[3:0]) : dec_char(idx, conv_neg, conv_digits);
  wire [7:0] head_char = (resp == R_DATA) ? `ASCP_CH_DATA : (resp == R_ACK) ? `ASCP_CH_ACK : `ASCP_CH_NAK;

  always_comb
  begin
    unique case (state)
      S_HEAD: tx_char = head_char;
      S_ADDR: tx_char = hex_char(idx[0] ? resp_addr[3:0] : resp_addr[7:4]);
      S_FIELD: tx_char = field_char;
      S_CKSUM: tx_char = hex_char(idx[0] ? tx_sum[3:0] : tx_sum[7:4]);
      S_CR: tx_char = `ASCP_CH_CR;
      default: tx_char = 8'h00;
    endcase
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE: next_state = (rx_take && !rx_cr) ? S_COLLECT : S_IDLE;
      S_COLLECT: next_state = (rx_take && rx_cr) ? S_EVAL : S_COLLECT;
      S_EVAL: next_state = silent ? S_IDLE : S_HEAD;
      S_HEAD: next_state = !load ? S_HEAD : (resp == R_DATA) ? S_CONV : S_ADDR;
      S_ADDR: next_state = (load && idx[0]) ? tail_state : S_ADDR;
      S_CONV: next_state = (conv_go && !conv_busy) ? S_FIELD : S_CONV;
      S_FIELD: next_state = !(load && last_idx) ? S_FIELD : (chan == `ASCP_LAST_CHAN) ? tail_state : S_CONV;
      S_CKSUM: next_state = (load && idx[0]) ? S_CR : S_CKSUM;
      S_CR: next_state = load ? S_IDLE : S_CR;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state <= S_IDLE;
      rx_ready <= 1'b0;
      resp <= R_NAK;
      resp_addr <= 8'h00;
    end
    else
    begin
      state <= next_state;
      rx_ready <= next_state inside {S_IDLE, S_COLLECT};
      resp <= (state == S_EVAL) ? (read_all ? R_DATA : cal_cmd ? R_ACK : R_NAK) : resp;
      resp_addr <= (state == S_EVAL) ? own_addr : resp_addr;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      idx <= 3'h0;
      chan <= 2'h0;
      conv_go <= 1'b0;
      tx_sum <= 8'h00;
    end
    else
    begin
      idx <= (state != next_state) ? 3'h0 : load ? idx + 3'h1 : idx;
      chan <= (state == S_EVAL) ? 2'h0 : (state == S_FIELD && next_state == S_CONV) ? chan + 2'h1 : chan;
      conv_go <= (state == S_CONV) & (next_state == S_CONV);
      tx_sum <= (state == S_EVAL) ? 8'h00 : (load && state != S_CKSUM) ? tx_sum + tx_char : tx_sum;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end
    else
    begin
      tx_valid <= load | (tx_valid & ~tx_ready);
      tx_data <= load ? tx_char : tx_data;
    end

  ascp_dec_conv u_conv (
    .clk(clk),
    .rst_n(rst_n),
    .start((state == S_CONV) & ~conv_go),
    .value(cur_val),
    .busy(conv_busy),
    .neg(conv_neg),
    .digits(conv_digits)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence eval_cal_s;
    do_cal ##0 is_offset;
  endsequence
  sequence data_head_s;
    state == S_HEAD && load && resp == R_DATA;
  endsequence

  modbus_no_cal_a: assert property (proto_modbus && $past(proto_modbus)
    |-> (off_done & ~$past(off_done)) == 4'h0)
    else $error("calibration happened in Modbus mode");
  offset_capture_a: assert property (eval_cal_s |=> cal_off[$past(cal_ch)] == $past(cal_pick))
    else $error("offset point not captured");
  gain_capture_a: assert property (do_cal && !is_offset |=> cal_gain[$past(cal_ch)] == $past(cal_pick))
    else $error("gain point not captured");
  addr_silent_a: assert property (state == S_EVAL && !addr_ok
    |=> state == S_IDLE ##1 state inside {S_IDLE, S_COLLECT})
    else $error("response to a foreign address");
  cksum_silent_a: assert property (state == S_EVAL && !ck_ok |=> state == S_IDLE)
    else $error("response to a frame with bad checksum");
  data_lead_a: assert property (data_head_s |=> tx_data == `ASCP_CH_DATA && state == S_CONV)
    else $error("data response lead wrong");
  nak_lead_a: assert property (state == S_HEAD && load && resp == R_NAK |=> tx_data == `ASCP_CH_NAK)
    else $error("invalid response lead wrong");
  frame_end_a: assert property (state == S_CR && load |=> tx_data == `ASCP_CH_CR && state == S_IDLE)
    else $error("response not ended by carriage return");
  cksum_value_a: assert property (state == S_CKSUM && load && !idx[0]
    |=> tx_data == hex_char($past(tx_sum[7:4])))
    else $error("checksum high digit wrong");
  cksum_place_a: assert property (state == S_CKSUM && load && idx[0] |=> state == S_CR)
    else $error("checksum not right before terminator");
  cr_discard_a: assert property (state == S_COLLECT && rx_take && rx_cr
    |=> state == S_EVAL ##1 state != S_COLLECT)
    else $error("frame not discarded at carriage return");
  disabled_space_a: assert property (state == S_FIELD && load && !ch_en[chan] |=> tx_data == `ASCP_CH_SPACE)
    else $error("disabled channel not shown as spaces");
  eng_point_a: assert property (state == S_FIELD && load && !is_hexfmt && ch_en[chan] && idx == 3'h3
    |=> tx_data == `ASCP_CH_POINT)
    else $error("decimal point misplaced");
endmodule
`default_nettype wire

// *** bench/ascp_host_model.sv ***
// Host-side serial sink that takes response characters and can stall.
`timescale 1ns/1ps
`default_nettype none
module ascp_host_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Response characters
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Stall control
  input wire logic slow
);
  logic [7:0] got[$];
  logic [1:0] phase;
  // When slow, the host is ready one cycle in four.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      tx_ready <= !slow || (phase == 2'h1);
    end
  end
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
    begin
      got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// *** bench/test_ascii_command_calibration_parser.sv ***
// Self-checking bench for the ASCII command parser.
`timescale 1ns/1ps
`default_nettype none
module test_ascii_command_calibration_parser
  import ascp_pkg::*;
;
  typedef struct {logic [7:0] adr; logic [7:0] fmt; logic [3:0] chen; logic proto; string cmd; string rsp;} ascp_row_t;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest, rx_valid, rx_ready, tx_valid, tx_ready, slow;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [7:0] rx_data, tx_data;
  ascp_value_t ch0, ch1, ch2, ch3;
  int num_errors, cmp_count, cycles;
  ascp_row_t rows[13];
  ascp_parser i_ascp_parser (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ch0_value(ch0), .ch1_value(ch1),
    .ch2_value(ch2), .ch3_value(ch3));
  ascp_host_model i_ascp_host_model (.clk(clk), .arst_n(arst_n), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .slow(slow));
  task test_done();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk("register", exp, r);
  endtask
  // sends a frame, optionally with long gaps
  task frame(input string cmd, input string rsp, input int gap);
    int n;
    i_ascp_host_model.got.delete();
    for (int i = 0; i < cmd.len(); i++)
    begin
      rx_data <= cmd[i];
      rx_valid <= 1'b1;
      do @(posedge clk); while (rx_ready !== 1'b1);
      if (gap > 0)
      begin
        rx_valid <= 1'b0;
        repeat (gap) @(posedge clk);
      end
    end
    rx_valid <= 1'b0;
    n = 0;
    while (n < 800 && !(i_ascp_host_model.got.size() > 0 && i_ascp_host_model.got[$] === 8'h0D))
    begin
      @(posedge clk);
      n++;
    end
    chk("resp_len", 32'(rsp.len()), 32'(i_ascp_host_model.got.size()));
    if (rsp.len() == i_ascp_host_model.got.size())
      for (int i = 0; i < rsp.len(); i++)
        chk("resp_char", {24'h0, rsp[i]}, {24'h0, i_ascp_host_model.got[i]});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      test_done();
    end
  end
  initial
  begin
    rows[0] = '{8'h01, 8'h00, 4'hF, 1'b0, "#01\r", ">+04.632-01.500+00.000+99.999\r"};
    rows[1] = '{8'h01, 8'h02, 4'h5, 1'b0, "#01\r", ">1218    0000    \r"};
    rows[2] = '{8'h01, 8'h01, 4'h2, 1'b0, "#01\r", ">       -01.500              \r"};
    rows[3] = '{8'h01, 8'h00, 4'hF, 1'b0, "#02\r", ""};
    rows[4] = '{8'h01, 8'h00, 4'hF, 1'b0, "%01\r", "?01\r"};
    rows[5] = '{8'h01, 8'h00, 4'hF, 1'b0, "$0114\r", "?01\r"};
    rows[6] = '{8'hAB, 8'h00, 4'hF, 1'b0, "$ab10\r", ""};
    rows[7] = '{8'hAB, 8'h00, 4'hF, 1'b0, "$AB10\r", "!AB\r"};
    rows[8] = '{8'h01, 8'h40, 4'hF, 1'b0, "$0110E6\r", "!0182\r"};
    rows[9] = '{8'h01, 8'h40, 4'hF, 1'b0, "$0110E7\r", ""};
    rows[10] = '{8'h01, 8'h00, 4'hF, 1'b1, "$0110\r", ""};
    rows[11] = '{8'h01, 8'h00, 4'hF, 1'b0, "$01123456789\r", ""};
    rows[12] = '{8'h01, 8'h42, 4'hF, 1'b0, "#0184\r", ">1218FA240000E24092\r"};
    arst_n = 1'b0;
    {avs_read, avs_write, rx_valid, slow} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    rx_data = 8'h00;
    ch0 = 20'h0_1218;
    ch1 = 20'hF_FA24;
    ch2 = 20'h0_0000;
    ch3 = 20'h1_E240;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(4'h0, 32'h0000_0001);
    rd_chk(4'h1, 32'h0000_0000);
    rd_chk(4'h2, 32'h0000_000F);
    foreach (rows[i])
    begin
      slow <= i[0];
      bus(1'b1, 4'h0, {24'h0, rows[i].adr});
      bus(1'b1, 4'h1, {24'h0, rows[i].fmt});
      bus(1'b1, 4'h2, {28'h0, rows[i].chen});
      bus(1'b1, 4'h3, {31'h0, rows[i].proto});
      frame(rows[i].cmd, rows[i].rsp, 0);
    end
    slow <= 1'b1;
    // The last row left the checksum on; the calibration frames below carry none.
    bus(1'b1, 4'h1, 32'h0000_0000);
    frame("$0112\r", "!01\r", 0);
    ch2 <= 20'h0_5DC0;
    repeat (2) @(posedge clk);
    frame("$0102\r", "!01\r", 0);
    frame("$0111\r", "!01\r", 0);
    rd_chk(4'hA, 32'h0000_0000);
    rd_chk(4'hE, 32'h0000_5DC0);
    rd_chk(4'h8, 32'h0000_1218);
    rd_chk(4'h9, 32'hFFFF_FA24);
    rd_chk(4'h4, 32'h0000_008E);
    bus(1'b1, 4'h4, 32'h0000_01FE);
    rd_chk(4'h4, 32'h0000_0000);
    bus(1'b1, 4'h5, 32'h1234_5678);
    rd_chk(4'h5, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0055);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(4'h0, 32'h0000_0001);
    ch2 <= 20'h0_0000;
    frame("#01\r", ">+04.632-01.500+00.000+99.999\r", 300);
    test_done();
  end
endmodule
`default_nettype wire
